// ==== hw/tpg_pkg.sv ====
// Constants and types for the timer pulse generator
package tpg_pkg;
  localparam int unsigned TPG_AW = 3;
  localparam logic [TPG_AW-1:0] TPG_CTRL_IDX   = 3'h0;
  localparam logic [TPG_AW-1:0] TPG_PERIOD_IDX = 3'h1;
  localparam logic [TPG_AW-1:0] TPG_WIDTH_IDX  = 3'h2;
  localparam logic [TPG_AW-1:0] TPG_COUNT_IDX  = 3'h3;
  localparam logic [TPG_AW-1:0] TPG_STAT_IDX   = 3'h4;
  localparam logic [TPG_AW-1:0] TPG_MASK_IDX   = 3'h5;
  // Control field positions
  localparam int unsigned TPG_SS_LSB   = 0;
  localparam int unsigned TPG_OS_BIT   = 2;
  localparam int unsigned TPG_IL_BIT   = 3;
  localparam int unsigned TPG_MODE_LSB = 4;
  localparam int unsigned TPG_PRE_LSB  = 8;
  // Status and mask bit positions
  localparam int unsigned TPG_EV_WIDTH  = 0;
  localparam int unsigned TPG_EV_PERIOD = 1;
  localparam int unsigned TPG_EV_STOP   = 2;
  // Reset values
  localparam logic [15:0] TPG_CTRL_RST = 16'h0000;
  localparam logic [15:0] TPG_CMP_RST  = 16'hffff;
  localparam logic [2:0]  TPG_MASK_RST = 3'h0;
  // Start select codes
  typedef enum logic [1:0] {
    TPG_SS_STOP = 2'h0,
    TPG_SS_CMD  = 2'h1,
    TPG_SS_RISE = 2'h2,
    TPG_SS_FALL = 2'h3
  } tpg_ss_type;
  // Mode field codes
  typedef enum logic [1:0] {
    TPG_MODE_TIMER = 2'h0,
    TPG_MODE_PULSE = 2'h1
  } tpg_mode_type;
  typedef enum logic [2:0] {
    TPG_ST_IDLE = 3'b001,
    TPG_ST_ARM  = 3'b010,
    TPG_ST_RUN  = 3'b100
  } tpg_state_type;
endpackage : tpg_pkg

// ==== hw/tpg_sync.sv ====
// Two-flop synchroniser with rise and fall detection
`timescale 1ns/1ps
`default_nettype none
module tpg_sync (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Pin and edges
  input  wire logic pin_i,
  output logic      rise_o,
  output logic      fall_o
);
  logic meta_r;
  logic sync_r;
  logic last_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      meta_r <= pin_i;
      sync_r <= meta_r;
      last_r <= sync_r;
    end
  end
  assign rise_o = sync_r & ~last_r;
  assign fall_o = ~sync_r & last_r;
endmodule : tpg_sync
`default_nettype wire

// ==== hw/tpg_top.sv ====
// Pulse generator timer with Wishbone register slave
//
// The implementer's own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module tpg_top
  import tpg_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Wishbone slave
  input  wire logic                 cyc_i,
  input  wire logic                 stb_i,
  input  wire logic                 we_i,
  input  wire logic [tpg_pkg::TPG_AW+1:0] adr_i,
  input  wire logic [3:0]           sel_i,
  input  wire logic [31:0]          dat_i,
  output logic      [31:0]          dat_o,
  output logic                      ack_o,
  // Pins
  input  wire logic                 trigger_input_i,
  output logic                      pulse_output_o,
  // Interrupt
  output logic                      timer_irq_o
);
  import tpg_pkg::*;

  logic [15:0]   ctrl_r;
  logic [15:0]   period_compare_r;
  logic [15:0]   width_compare_r;
  logic [15:0]   count_r;
  logic [7:0]    pre_r;
  logic          output_flop_r;
  logic [2:0]    status_r;
  logic [2:0]    mask_r;
  logic          ack_r;
  logic [31:0]   dat_r;
  tpg_state_type state_r;
  tpg_state_type state_nxt;

  logic         trig_rise;
  logic         trig_fall;
  logic         req;
  logic         wr;
  logic         rd;
  logic [TPG_AW-1:0] idx;
  logic [1:0]   start_select;
  logic         oneshot_select;
  logic         initial_level_bit;
  logic [1:0]   mode_field;
  logic [7:0]   pre_div;
  logic         tick;
  logic         running;
  logic         width_hit;
  logic         period_hit;
  logic         stop_auto;
  logic         ctrl_wr;
  logic [15:0]  ctrl_wdat;
  logic         trig_edge;

  tpg_sync u_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (trigger_input_i),
    .rise_o (trig_rise),
    .fall_o (trig_fall)
  );

  assign idx               = adr_i[TPG_AW+1:2];
  // Writes land on the edge that samples ack high, reads load data a cycle before
  assign req               = cyc_i & stb_i & ~ack_r;
  assign wr                = cyc_i & stb_i & we_i & ack_r;
  assign rd                = req & ~we_i;
  assign start_select      = ctrl_r[TPG_SS_LSB +: 2];
  assign oneshot_select    = ctrl_r[TPG_OS_BIT];
  assign initial_level_bit = ctrl_r[TPG_IL_BIT];
  assign mode_field        = ctrl_r[TPG_MODE_LSB +: 2];
  assign pre_div           = ctrl_r[TPG_PRE_LSB +: 8];
  assign ctrl_wr           = wr && idx == TPG_CTRL_IDX;
  assign ctrl_wdat         = {sel_i[1] ? dat_i[15:8] : ctrl_r[15:8], sel_i[0] ? dat_i[7:0] : ctrl_r[7:0]};

  // Internal source clock: divided system clock, never the pin
  assign tick       = (pre_r == pre_div);
  assign running    = (state_r == TPG_ST_RUN) && (mode_field == TPG_MODE_PULSE);
  assign width_hit  = running && tick && (count_r == width_compare_r);
  assign period_hit = running && tick && (count_r == period_compare_r);
  assign stop_auto  = period_hit && oneshot_select;
  assign trig_edge  = (start_select == TPG_SS_RISE) ? trig_rise : trig_fall;

  // Start control
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      TPG_ST_IDLE: begin
        if (start_select == TPG_SS_CMD) begin
          state_nxt = TPG_ST_RUN;
        end else if (start_select != TPG_SS_STOP) begin
          state_nxt = TPG_ST_ARM;
        end
      end
      TPG_ST_ARM: begin
        if (start_select == TPG_SS_STOP || start_select == TPG_SS_CMD) begin
          state_nxt = TPG_ST_IDLE;
        end else if (trig_edge) begin
          state_nxt = TPG_ST_RUN;
        end
      end
      TPG_ST_RUN: begin
        if (start_select == TPG_SS_STOP || stop_auto) begin
          state_nxt = TPG_ST_IDLE;
        end
      end
      default: state_nxt = TPG_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= TPG_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Prescaler and up-counter
  always_ff @(posedge clk_i) begin
    if (rst_i || state_r != TPG_ST_RUN || tick) begin
      pre_r <= 8'h00;
    end else begin
      pre_r <= pre_r + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || state_r != TPG_ST_RUN) begin
      count_r <= 16'h0000;
    end else if (period_hit) begin
      count_r <= 16'h0000;
    end else if (tick) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // Output flop; reloads only on entry to pulse mode from timer mode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      output_flop_r <= 1'b0;
    end else if (ctrl_wr && mode_field == TPG_MODE_TIMER
                 && ctrl_wdat[TPG_MODE_LSB +: 2] == TPG_MODE_PULSE) begin
      output_flop_r <= ctrl_wdat[TPG_IL_BIT];
    end else if (width_hit || period_hit) begin
      output_flop_r <= ~output_flop_r;
    end
  end
  // Stopped timer simply leaves the flop alone
  assign pulse_output_o = ~output_flop_r;

  // Control register; hardware stop wins over a software write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= TPG_CTRL_RST;
    end else begin
      if (ctrl_wr) begin
        ctrl_r <= ctrl_wdat;
      end
      if (stop_auto) begin
        ctrl_r[TPG_SS_LSB +: 2] <= TPG_SS_STOP;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_compare_r <= TPG_CMP_RST;
      width_compare_r  <= TPG_CMP_RST;
      mask_r           <= TPG_MASK_RST;
    end else if (wr) begin
      case (idx)
        TPG_PERIOD_IDX: begin
          if (sel_i[0]) period_compare_r[7:0]  <= dat_i[7:0];
          if (sel_i[1]) period_compare_r[15:8] <= dat_i[15:8];
        end
        TPG_WIDTH_IDX: begin
          if (sel_i[0]) width_compare_r[7:0]  <= dat_i[7:0];
          if (sel_i[1]) width_compare_r[15:8] <= dat_i[15:8];
        end
        TPG_MASK_IDX: begin
          if (sel_i[0]) mask_r <= dat_i[2:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_r <= 3'h0;
    end else begin
      status_r <= (status_r & ~((wr && idx == TPG_STAT_IDX && sel_i[0]) ? dat_i[2:0] : 3'h0))
                | {stop_auto, period_hit, width_hit};
    end
  end

  assign timer_irq_o = |(status_r & mask_r);

  // Bus answer: one wait state, unmapped reads give zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= req;
      if (rd) begin
        case (idx)
          TPG_CTRL_IDX:   dat_r <= {16'h0000, ctrl_r};
          TPG_PERIOD_IDX: dat_r <= {16'h0000, period_compare_r};
          TPG_WIDTH_IDX:  dat_r <= {16'h0000, width_compare_r};
          TPG_COUNT_IDX:  dat_r <= {16'h0000, count_r};
          TPG_STAT_IDX:   dat_r <= {28'h0000000, output_flop_r, status_r};
          TPG_MASK_IDX:   dat_r <= {29'h0, mask_r};
          default:        dat_r <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign ack_o = ack_r;
  assign dat_o = dat_r;
endmodule : tpg_top
`default_nettype wire

// ==== tb/tpg_top_sva.sv ====
// Port-level checker for the pulse generator timer
`timescale 1ns/1ps
`default_nettype none
module tpg_top_sva (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Wishbone
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [4:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  // Pins and interrupt
  input wire logic        trigger_input_i,
  input wire logic        pulse_output_o,
  input wire logic        timer_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  a_ack_single_pulse: assert property (disable iff (rst_i) ack_o |=> !ack_o) else $error("ack longer than one cycle");
  a_ack_follows_req:  assert property (disable iff (rst_i) cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acked next cycle");
  a_ack_has_req:      assert property (disable iff (rst_i) ack_o |-> $past(cyc_i && stb_i)) else $error("stray ack");
  a_reset_pin_high:   assert property (rst_i |=> pulse_output_o) else $error("pin not high after reset");
  a_reset_irq_low:    assert property (rst_i |=> !timer_irq_o) else $error("irq set after reset");
  a_reset_no_ack:     assert property (rst_i |=> !ack_o) else $error("ack during reset");
  a_irq_clear_write:  assert property (disable iff (rst_i) $fell(timer_irq_o) |-> $past(cyc_i && we_i))
    else $error("irq fell without a write");
  a_read_upper_zero:  assert property (disable iff (rst_i) ack_o && !we_i |-> dat_o[31:16] == 16'h0000)
    else $error("upper read half not zero");
  c_irq_raised: cover property (disable iff (rst_i) $rose(timer_irq_o));
  c_pin_fell:   cover property (disable iff (rst_i) $fell(pulse_output_o));
  c_trig_rise:  cover property (disable iff (rst_i) $rose(trigger_input_i));
endmodule : tpg_top_sva
bind tpg_top tpg_top_sva i_sva (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .trigger_input_i(trigger_input_i), .pulse_output_o(pulse_output_o), .timer_irq_o(timer_irq_o));
`default_nettype wire

// ==== tb/tpg_pin_model.sv ====
// Far-side pins: trigger source and pulse level timer
`timescale 1ns/1ps
`default_nettype none
module tpg_pin_model (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Pins
  input  wire logic        pin_i,
  input  wire logic        trig_req_i,
  output logic             trigger_o,
  // Measurements
  output int               toggles_o,
  output int               hi_len_o,
  output int               lo_len_o
);
  logic prev_r;
  int   run_r;
  initial trigger_o = 1'b0;
  always @(posedge clk_i) begin
    trigger_o <= trig_req_i;
    prev_r    <= pin_i;
    if (rst_i) begin
      toggles_o <= 0;
      run_r     <= 1;
    end else if (pin_i !== prev_r) begin
      toggles_o <= toggles_o + 1;
      if (prev_r) hi_len_o <= run_r;
      else lo_len_o <= run_r;
      run_r <= 1;
    end else run_r <= run_r + 1;
  end
endmodule : tpg_pin_model
`default_nettype wire

// ==== tb/tpg_top_test.sv ====
// Register-level tests of the pulse generator timer
`timescale 1ns/1ps
`default_nettype none
module tpg_top_test;
  import tpg_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, irq, pin, trig, treq = 0;
  logic [4:0] adr = '0;
  logic [31:0] dat = '0, rdat, q;
  int fail_count = 0, tests_run = 0, tog, hi, lo, snap;
  tpg_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(4'h3), .dat_i(dat), .dat_o(rdat), .ack_o(ack), .trigger_input_i(trig),
    .pulse_output_o(pin), .timer_irq_o(irq));
  tpg_pin_model i_pins (.clk_i(clk_i), .rst_i(rst_i), .pin_i(pin), .trig_req_i(treq), .trigger_o(trig),
    .toggles_o(tog), .hi_len_o(hi), .lo_len_o(lo));
  initial forever #25 clk_i = ~clk_i;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [2:0] ix, input logic [15:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, ix, 2'b00, 16'h0000, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb, we} <= 3'b000;
  endtask : acc
  task automatic rd(input string nm, input logic [2:0] ix, input logic [15:0] m, input logic [15:0] e);
    acc(1'b0, ix, 16'h0);
    chk(nm, q & {16'h0, m}, {16'h0, e});
  endtask : rd
  task automatic conclude();
    $display("Checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  initial begin
    #400000;
    fail_count++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    chk("pin", pin, 1);
    rd("ctrl", TPG_CTRL_IDX, 16'hffff, 16'h0000);
    rd("period", TPG_PERIOD_IDX, 16'hffff, 16'hffff);
    rd("width", TPG_WIDTH_IDX, 16'hffff, 16'hffff);
    rd("unmapped", 3'h6, 16'hffff, 16'h0000);
    $display("Test reset done");
    acc(1, TPG_MASK_IDX, 16'h0007);
    acc(1, TPG_CTRL_IDX, 16'h0010);
    acc(1, TPG_PERIOD_IDX, 16'h0009);
    acc(1, TPG_WIDTH_IDX, 16'h0003);
    acc(1, TPG_CTRL_IDX, 16'h0011);
    while (tog < 5) @(posedge clk_i);
    chk("high_len", hi, 4);
    chk("low_len", lo, 6);
    rd("status", TPG_STAT_IDX, 16'h0003, 16'h0003);
    chk("irq", irq, 1);
    acc(1, TPG_CTRL_IDX, 16'h0010);
    // Let a toggle still in flight reach the pin model first
    repeat (3) @(posedge clk_i);
    snap = tog;
    repeat (30) @(posedge clk_i);
    chk("hold", tog, snap);
    acc(1, TPG_STAT_IDX, 16'h0007);
    rd("status_clr", TPG_STAT_IDX, 16'h0007, 16'h0000);
    chk("irq_clr", irq, 0);
    $display("Test continuous done");
    acc(1, TPG_CTRL_IDX, 16'h0000);
    acc(1, TPG_CTRL_IDX, 16'h0010);
    @(posedge clk_i);
    chk("reload", pin, 1);
    acc(1, TPG_MASK_IDX, 16'h0000);
    acc(1, TPG_CTRL_IDX, 16'h0015);
    repeat (40) @(posedge clk_i);
    rd("oneshot_ctrl", TPG_CTRL_IDX, 16'hffff, 16'h0014);
    rd("oneshot_st", TPG_STAT_IDX, 16'h0007, 16'h0007);
    chk("irq_masked", irq, 0);
    chk("final", pin, 1);
    $display("Test oneshot done");
    acc(1, TPG_CTRL_IDX, 16'h0000);
    acc(1, TPG_CTRL_IDX, 16'h0018);
    @(posedge clk_i);
    chk("level_low", pin, 0);
    acc(1, TPG_CTRL_IDX, 16'h001a);
    snap = tog;
    repeat (20) @(posedge clk_i);
    chk("no_start", tog, snap);
    treq <= 1;
    repeat (30) @(posedge clk_i);
    chk("trig_start", tog > snap, 1);
    $display("Test trigger done");
    acc(1, TPG_CTRL_IDX, 16'h0018);
    acc(1, TPG_CTRL_IDX, 16'h001b);
    repeat (3) @(posedge clk_i);
    snap = tog;
    repeat (20) @(posedge clk_i);
    chk("no_fall_start", tog, snap);
    treq <= 0;
    repeat (30) @(posedge clk_i);
    chk("fall_start", tog > snap, 1);
    $display("Test falling trigger done");
    acc(1, TPG_CTRL_IDX, 16'h0000);
    acc(1, TPG_CTRL_IDX, 16'h0110);
    acc(1, TPG_CTRL_IDX, 16'h0111);
    snap = tog;
    while (tog < snap + 5) @(posedge clk_i);
    chk("pre_high_len", hi, 8);
    chk("pre_low_len", lo, 12);
    $display("Test prescale done");
    conclude();
  end
endmodule : tpg_top_test
`default_nettype wire
